// ### src/sc_parity_pkg.sv
// constants and types for the smart card parity, break and card clock block
`default_nettype none
package sc_parity_pkg;
  // register indices, byte address is four times the index
  localparam logic [15:0] IDX_CLK_DIV = 16'hFE10;
  localparam logic [15:0] IDX_PAR_CTL = 16'hFE11;
  localparam logic [15:0] IDX_BRK_CTL = 16'hFE20;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hFE21;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hFE22;
  // reset values and writable masks
  localparam logic [7:0] RST_CLK_DIV = 8'h0C;
  localparam logic [7:0] RST_PAR_CTL = 8'h00;
  localparam logic [7:0] MSK_CLK_DIV = 8'h3F;
  localparam logic [7:0] MSK_PAR_CTL = 8'h7F;
  localparam logic [7:0] MSK_BRK_CTL = 8'h03;
  localparam logic [7:0] MSK_IRQ = 8'h07;
  // interrupt status bit positions
  localparam int IRQ_PAR_ERR = 0;
  localparam int IRQ_BRK_DET = 1;
  localparam int IRQ_DISCARD = 2;
  // timing in half etu steps
  localparam logic [4:0] HALF_RX_BREAK = 5'h15;
  localparam logic [4:0] HALF_TX_SAMPLE = 5'h16;
  localparam logic [2:0] HALF_BRK_1 = 3'h2;
  localparam logic [2:0] HALF_BRK_15 = 3'h3;
  localparam logic [2:0] HALF_BRK_2 = 3'h4;

  // parity control fields, msb first
  typedef struct packed {
    logic rsvd;
    logic parity_check_disable;
    logic break_generation_disable;
    logic break_detection_disable;
    logic retransmit_on_break;
    logic discard_on_parity_error;
    logic insert_tx_parity_error;
    logic force_rx_parity_error;
  } par_ctl_t;

  // a received character with its parity bit
  typedef struct packed {
    logic [7:0] data;
    logic parity;
  } rx_char_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RX = 4'b0010,
    S_BRK = 4'b0100,
    S_TX = 4'b1000
  } brk_state_t;
endpackage
`default_nettype wire

// ### src/sc_parity_clk.sv
// card clock divider, parity check and generation, break handling, apb registers
//
// The APB interface to the registers is this design's own decision.
`default_nettype none
module sc_parity_clk (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // card clock
  output logic o_card_clk,
  output logic o_etu_clk_en,
  // uart core side
  input wire logic i_proto_t1,
  input wire logic i_half_etu,
  input wire logic i_rx_start,
  input wire logic i_rx_done,
  input wire sc_parity_pkg::rx_char_t i_rx_char,
  input wire logic i_tx_start,
  input wire logic [7:0] i_tx_data,
  input wire logic i_io_line,
  output logic o_io_drive_low,
  output logic o_tx_parity,
  output logic o_tx_retry,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_par_err,
  // interrupt
  output logic o_irq
);

  logic [7:0] div_r, div_nxt;
  sc_parity_pkg::par_ctl_t pc_r, pc_nxt;
  logic [1:0] bdur_r, bdur_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic [5:0] div_cnt_r, div_cnt_nxt;
  logic [5:0] div_act_r, div_act_nxt;
  logic etu_en_r, etu_en_nxt;
  logic card_clk_r, card_clk_nxt;
  sc_parity_pkg::brk_state_t st_r, st_nxt;
  logic [4:0] hcnt_r, hcnt_nxt;
  logic [2:0] blen_r, blen_nxt;
  logic err_r, err_nxt;
  logic rx_valid_r, rx_valid_nxt;
  logic [7:0] rx_data_r, rx_data_nxt;
  logic rx_err_r, rx_err_nxt;
  logic tx_par_r, tx_par_nxt;
  logic retry_r, retry_nxt;
  logic wr, rd_hit;
  logic [15:0] idx;
  logic t0, rx_err, drop, gen_brk, card_brk;
  logic [2:0] ev;

  // zero wait slave, so the bus never stalls behind the link
  assign idx = i_paddr[17:2];
  assign wr = i_psel && i_penable && i_pwrite;
  assign o_pready = 1'b1;
  assign rd_hit = (idx == sc_parity_pkg::IDX_CLK_DIV) || (idx == sc_parity_pkg::IDX_PAR_CTL) ||
                  (idx == sc_parity_pkg::IDX_BRK_CTL) || (idx == sc_parity_pkg::IDX_IRQ_STAT) ||
                  (idx == sc_parity_pkg::IDX_IRQ_MASK);
  assign o_pslverr = i_psel && i_penable && !rd_hit;

  // read mux, unused bits stay zero
  always_comb begin
    o_prdata = 32'h0000_0000;
    unique case (idx)
      sc_parity_pkg::IDX_CLK_DIV: o_prdata[7:0] = div_r;
      sc_parity_pkg::IDX_PAR_CTL: o_prdata[7:0] = pc_r;
      sc_parity_pkg::IDX_BRK_CTL: o_prdata[1:0] = bdur_r;
      sc_parity_pkg::IDX_IRQ_STAT: o_prdata[2:0] = stat_r;
      sc_parity_pkg::IDX_IRQ_MASK: o_prdata[2:0] = mask_r;
      default: o_prdata = 32'h0000_0000;
    endcase
  end

  // one parity control for both interfaces; no per-card copy exists
  assign t0 = !i_proto_t1;
  assign rx_err = (!pc_r.parity_check_disable && (^{i_rx_char.data, i_rx_char.parity})) ||
                  pc_r.force_rx_parity_error;
  assign drop = rx_err && t0 && pc_r.discard_on_parity_error &&
                !pc_r.parity_check_disable;
  assign gen_brk = err_r && t0 && !pc_r.break_generation_disable &&
                   !pc_r.parity_check_disable;
  assign card_brk = !i_io_line && t0 && !pc_r.break_detection_disable;

  // register writes and sticky events, a set beats a same-cycle clear
  always_comb begin
    div_nxt = div_r;
    pc_nxt = pc_r;
    bdur_nxt = bdur_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    ev = 3'h0;
    ev[sc_parity_pkg::IRQ_PAR_ERR] = i_rx_done && (st_r == sc_parity_pkg::S_RX) && rx_err;
    ev[sc_parity_pkg::IRQ_DISCARD] = i_rx_done && (st_r == sc_parity_pkg::S_RX) && drop;
    ev[sc_parity_pkg::IRQ_BRK_DET] = (st_r == sc_parity_pkg::S_TX) && i_half_etu &&
                                     (hcnt_r == sc_parity_pkg::HALF_TX_SAMPLE - 5'h01) && card_brk;
    if (wr) begin
      unique case (idx)
        sc_parity_pkg::IDX_CLK_DIV: div_nxt = i_pwdata[7:0] &
                                              sc_parity_pkg::MSK_CLK_DIV;
        sc_parity_pkg::IDX_PAR_CTL: pc_nxt = i_pwdata[7:0] & sc_parity_pkg::MSK_PAR_CTL;
        sc_parity_pkg::IDX_BRK_CTL: bdur_nxt = i_pwdata[1:0];
        sc_parity_pkg::IDX_IRQ_STAT: stat_nxt = stat_r & ~i_pwdata[2:0];
        sc_parity_pkg::IDX_IRQ_MASK: mask_nxt = i_pwdata[2:0];
        default: ;
      endcase
    end
    stat_nxt = stat_nxt | ev;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_r <= sc_parity_pkg::RST_CLK_DIV;
      pc_r <= sc_parity_pkg::RST_PAR_CTL;
      bdur_r <= 2'h0;
      stat_r <= 3'h0;
      mask_r <= 3'h0;
    end else begin
      div_r <= div_nxt;
      pc_r <= pc_nxt;
      bdur_r <= bdur_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign o_irq = |(stat_r & mask_r);

  // card clock divider; the ratio is reloaded only at wrap so no short pulse escapes
  always_comb begin
    div_cnt_nxt = div_cnt_r + 6'h01;
    div_act_nxt = div_act_r;
    etu_en_nxt = 1'b0;
    card_clk_nxt = card_clk_r;
    if (div_cnt_r >= div_act_r) begin
      div_cnt_nxt = 6'h00;
      etu_en_nxt = 1'b1;
      card_clk_nxt = !card_clk_r;
      div_act_nxt = (div_r[5:0] == 6'h00) ? 6'h01 : div_r[5:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt_r <= 6'h00;
      div_act_r <= sc_parity_pkg::RST_CLK_DIV[5:0];
      etu_en_r <= 1'b0;
      card_clk_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      div_act_r <= div_act_nxt;
      etu_en_r <= etu_en_nxt;
      card_clk_r <= card_clk_nxt;
    end
  end

  assign o_card_clk = card_clk_r;
  assign o_etu_clk_en = etu_en_r;

  // character framing: break window on receive, break sample on transmit
  always_comb begin
    st_nxt = st_r;
    hcnt_nxt = hcnt_r;
    blen_nxt = blen_r;
    err_nxt = err_r;
    rx_valid_nxt = 1'b0;
    rx_data_nxt = rx_data_r;
    rx_err_nxt = rx_err_r;
    retry_nxt = 1'b0;
    tx_par_nxt = (^i_tx_data) ^ pc_r.insert_tx_parity_error;
    unique case (st_r)
      sc_parity_pkg::S_IDLE: begin
        hcnt_nxt = 5'h00;
        err_nxt = 1'b0;
        if (i_rx_start) begin
          st_nxt = sc_parity_pkg::S_RX;
        end else if (i_tx_start) begin
          st_nxt = sc_parity_pkg::S_TX;
        end
      end
      sc_parity_pkg::S_RX: begin
        if (i_half_etu) begin
          hcnt_nxt = hcnt_r + 5'h01;
        end
        if (i_rx_done) begin
          err_nxt = rx_err;
          rx_err_nxt = rx_err;
          rx_data_nxt = i_rx_char.data;
          rx_valid_nxt = !drop;
        end
        if (i_half_etu && hcnt_r == sc_parity_pkg::HALF_RX_BREAK - 5'h01) begin
          hcnt_nxt = 5'h00;
          st_nxt = gen_brk ? sc_parity_pkg::S_BRK : sc_parity_pkg::S_IDLE;
          unique case (bdur_r)
            2'h1: blen_nxt = sc_parity_pkg::HALF_BRK_15;
            2'h2: blen_nxt = sc_parity_pkg::HALF_BRK_2;
            default: blen_nxt = sc_parity_pkg::HALF_BRK_1; // reserved code acts as 1 etu
          endcase
        end
      end
      sc_parity_pkg::S_BRK: begin
        if (i_half_etu) begin
          hcnt_nxt = hcnt_r + 5'h01;
          if (hcnt_r[2:0] == blen_r - 3'h1) begin
            st_nxt = sc_parity_pkg::S_IDLE;
          end
        end
      end
      sc_parity_pkg::S_TX: begin
        if (i_half_etu) begin
          hcnt_nxt = hcnt_r + 5'h01;
          if (hcnt_r == sc_parity_pkg::HALF_TX_SAMPLE - 5'h01) begin
            st_nxt = sc_parity_pkg::S_IDLE;
            retry_nxt = card_brk && pc_r.retransmit_on_break;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= sc_parity_pkg::S_IDLE;
      hcnt_r <= 5'h00;
      blen_r <= sc_parity_pkg::HALF_BRK_1;
      err_r <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_data_r <= 8'h00;
      rx_err_r <= 1'b0;
      tx_par_r <= 1'b0;
      retry_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      hcnt_r <= hcnt_nxt;
      blen_r <= blen_nxt;
      err_r <= err_nxt;
      rx_valid_r <= rx_valid_nxt;
      rx_data_r <= rx_data_nxt;
      rx_err_r <= rx_err_nxt;
      tx_par_r <= tx_par_nxt;
      retry_r <= retry_nxt;
    end
  end

  assign o_io_drive_low = (st_r == sc_parity_pkg::S_BRK);
  assign o_tx_parity = tx_par_r;
  assign o_tx_retry = retry_r;
  assign o_rx_valid = rx_valid_r;
  assign o_rx_data = rx_data_r;
  assign o_rx_par_err = rx_err_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sequence rx_done_s;
    (st_r == sc_parity_pkg::S_RX) && i_rx_done;
  endsequence

  a_div_never_zero: assert property (div_act_r != 6'h00)
    else $error("active divide ratio is zero");
  a_clk_only_on_en: assert property ($changed(card_clk_r) |-> etu_en_r)
    else $error("card clock moved without etu enable");
  a_ratio_at_wrap: assert property ($changed(div_act_r) |->
      etu_en_r && div_cnt_r == 6'h00)
    else $error("divide ratio changed mid period");
  a_en_spacing: assert property (etu_en_r |=> !etu_en_r)
    else $error("etu enable on back to back cycles");
  a_rx_deliver: assert property (rx_done_s ##0 !drop |=>
      o_rx_valid && o_rx_data == $past(i_rx_char.data))
    else $error("clean character not delivered");
  a_rx_discard: assert property (rx_done_s ##0 drop |=> !o_rx_valid && o_rx_par_err)
    else $error("errored character not dropped");
  a_brk_cause: assert property ($rose(o_io_drive_low) |-> $past(gen_brk))
    else $error("break without enabled parity error");
  a_tx_parity: assert property (##1 o_tx_parity ==
      ((^$past(i_tx_data)) ^ $past(pc_r.insert_tx_parity_error)))
    else $error("transmit parity wrong");
  a_force_err: assert property (rx_done_s ##0
      pc_r.force_rx_parity_error |=> o_rx_par_err)
    else $error("forced parity error missing");
  a_retry_cause: assert property (o_tx_retry |->
      $past(card_brk && pc_r.retransmit_on_break))
    else $error("retry without card break");

  // break placement and length follow the half etu count, not the rx done strobe
  sequence rx_brk_point_s;
    (st_r == sc_parity_pkg::S_RX) && i_half_etu &&
        (hcnt_r == sc_parity_pkg::HALF_RX_BREAK - 5'h01);
  endsequence

  a_brk_start: assert property (rx_brk_point_s ##0 gen_brk |=> o_io_drive_low)
    else $error("break not raised at its point");
  a_brk_end: assert property ($fell(o_io_drive_low) |->
      $past(i_half_etu && hcnt_r[2:0] == blen_r - 3'h1))
    else $error("break ended off its length");
  a_tx_sample: assert property (o_tx_retry |->
      $past(st_r == sc_parity_pkg::S_TX && hcnt_r == sc_parity_pkg::HALF_TX_SAMPLE - 5'h01))
    else $error("card break sampled off its point");
  a_brk_detect: assert property ($rose(stat_r[sc_parity_pkg::IRQ_BRK_DET]) |->
      $past(t0 && !pc_r.break_detection_disable))
    else $error("card break flagged while detection off");

endmodule
`default_nettype wire

// ### dv/sc_card_model.sv
// card side model: half etu pacing and an open-drain io line
`default_nettype none
module sc_card_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // line control
  input wire logic i_card_brk,
  input wire logic i_drive_low,
  // pacing and line level
  output logic o_half_etu,
  output logic o_io_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r;

  // half etu every four cycles keeps whole frames short
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign o_half_etu = (div_r == 2'h3);
  // pulled up, low while either party holds it; card break after a sent char
  assign o_io_line = ~(i_card_brk | i_drive_low);
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the card clock, parity and break block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, card_clk, etu_en, proto_t1, half;
  logic rx_start, rx_done, tx_start, io_line, drive_low, tx_par, tx_retry;
  logic rx_valid, rx_err, irq, card_brk;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0] tx_data, rx_data;
  sc_parity_pkg::rx_char_t rx_char;
  int fail_count = 0;
  int n_tests = 0;
  int hcnt = 0;
  int lens [4] = '{2, 3, 4, 2};

  // 100 MHz clock
  always #5 clk = ~clk;
  // running count of half etu pulses, used to place line events
  always @(posedge clk) if (half) hcnt <= hcnt + 1;

  sc_parity_clk u_sc_parity_clk (
    .i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_card_clk(card_clk),
    .o_etu_clk_en(etu_en), .i_proto_t1(proto_t1), .i_half_etu(half),
    .i_rx_start(rx_start), .i_rx_done(rx_done), .i_rx_char(rx_char),
    .i_tx_start(tx_start), .i_tx_data(tx_data), .i_io_line(io_line),
    .o_io_drive_low(drive_low), .o_tx_parity(tx_par), .o_tx_retry(tx_retry),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_par_err(rx_err), .o_irq(irq)
  );
  sc_card_model u_sc_card_model (.i_sys_clk(clk), .i_nrst(nrst), .i_card_brk(card_brk),
    .i_drive_low(drive_low), .o_half_etu(half), .o_io_line(io_line));

  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task step;
    @(posedge clk);
    #1;
  endtask

  // one apb transfer; waits on pready rather than assuming zero wait
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) fail_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, {24'h0, d}, r, e);
  endtask

  task rdc(input string nm, input logic [15:0] idx, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(nm, x, r);
  endtask

  // skip the pulse that may still use the old ratio, then measure a gap
  task gap(input logic [31:0] e);
    int k;
    logic c;
    for (int j = 0; j < 3; j++) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (etu_en !== 1'b1 && k < 300);
      if (j == 1) c = card_clk;
    end
    chk("etu gap", e, k);
    chk("card clk toggled", 32'h1, 32'(c ^ card_clk));
  endtask

  // receive one char, then time any break in half etu from the start
  task rx(input logic [7:0] d, input logic p, input logic v, input logic er,
          input int rise, input int len);
    int h0, hr, r0, l0, k;
    @(posedge clk);
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
    rx_done <= 1'b1;
    rx_char <= {d, p};
    #1 h0 = hcnt;
    @(posedge clk);
    rx_done <= 1'b0;
    #1;
    chk("rx valid", 32'(v), 32'(rx_valid));
    if (v) chk("rx parity error", 32'(er), 32'(rx_err));
    if (v) chk("rx data", 32'(d), 32'(rx_data));
    r0 = 0;
    l0 = 0;
    hr = 0;
    k = 0;
    while (hcnt - h0 < 30 && k < 300) begin
      step;
      k++;
      if (drive_low === 1'b1 && r0 == 0) r0 = hcnt - h0;
      if (drive_low === 1'b1 && hr == 0) hr = hcnt;
      if (drive_low !== 1'b1 && r0 != 0 && l0 == 0) l0 = hcnt - hr;
    end
    if (k >= 300) fail_count++;
    chk("break start", rise, r0);
    chk("break length", len, l0);
  endtask

  // send one char; card may break around the 11 etu sample point
  task tx(input logic [7:0] d, input logic par, input logic brk, input logic rt);
    int h0;
    @(posedge clk);
    tx_start <= 1'b1;
    tx_data <= d;
    @(posedge clk);
    tx_start <= 1'b0;
    #1 h0 = hcnt;
    chk("tx parity", 32'(par), 32'(tx_par));
    while (hcnt - h0 < 20) step;
    @(posedge clk);
    card_brk <= brk;
    while (hcnt - h0 < 22) step;
    chk("tx retry", 32'(rt), 32'(tx_retry));
    @(posedge clk);
    card_brk <= 1'b0;
    while (hcnt - h0 < 26) step;
  endtask

  task t_regs;
    logic [31:0] r;
    logic e;
    rdc("clk div reset", sc_parity_pkg::IDX_CLK_DIV, 32'h0000000C);
    rdc("par ctl reset", sc_parity_pkg::IDX_PAR_CTL, 32'h00000000);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'hFF);
    rdc("par ctl unused", sc_parity_pkg::IDX_PAR_CTL, 32'h0000007F);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h00);
    apb(1'b1, 16'hFE30, 32'h000000FF, r, e);
    chk("unmapped error", 32'h1, 32'(e));
    apb(1'b0, 16'hFE30, 32'h0, r, e);
    chk("unmapped data", 32'h0, r);
  endtask

  task t_clk;
    gap(32'd13);
    wr(sc_parity_pkg::IDX_CLK_DIV, 8'h00);
    gap(32'd2);
    wr(sc_parity_pkg::IDX_CLK_DIV, 8'hC5);
    rdc("clk div unused", sc_parity_pkg::IDX_CLK_DIV, 32'h00000005);
    gap(32'd6);
  endtask

  // 0xA5 has four ones: parity 0 is good, 1 is an error
  task t_rx;
    rx(8'hA5, 1'b0, 1'b1, 1'b0, 0, 0);
    for (int b = 0; b < 4; b++) begin
      wr(sc_parity_pkg::IDX_BRK_CTL, 8'(b));
      rx(8'hA5, 1'b1, 1'b1, 1'b1, 21, lens[b]);
    end
    wr(sc_parity_pkg::IDX_BRK_CTL, 8'h00);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h40);
    rx(8'hA5, 1'b1, 1'b1, 1'b0, 0, 0);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h41);
    rx(8'hA5, 1'b0, 1'b1, 1'b1, 0, 0);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h01);
    rx(8'hA5, 1'b0, 1'b1, 1'b1, 21, 2);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h20);
    rx(8'hA5, 1'b1, 1'b1, 1'b1, 0, 0);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h04);
    rx(8'hA5, 1'b1, 1'b0, 1'b1, 21, 2);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h00);
    proto_t1 <= 1'b1;
    rx(8'hA5, 1'b1, 1'b1, 1'b1, 0, 0);
    proto_t1 <= 1'b0;
    rdc("irq status", sc_parity_pkg::IDX_IRQ_STAT, 32'h00000005);
    chk("irq masked", 32'h0, 32'(irq));
    wr(sc_parity_pkg::IDX_IRQ_MASK, 8'h01);
    #1 chk("irq raised", 32'h1, 32'(irq));
    wr(sc_parity_pkg::IDX_IRQ_STAT, 8'h07);
    #1 chk("irq cleared", 32'h0, 32'(irq));
  endtask

  task t_tx;
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h08);
    tx(8'hA5, 1'b0, 1'b1, 1'b1);
    tx(8'h07, 1'b1, 1'b0, 1'b0);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h0A);
    tx(8'hA5, 1'b1, 1'b0, 1'b0);
    rdc("break status", sc_parity_pkg::IDX_IRQ_STAT, 32'h00000002);
    wr(sc_parity_pkg::IDX_IRQ_STAT, 8'h07);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h18);
    tx(8'hA5, 1'b0, 1'b1, 1'b0);
    rdc("break ignored", sc_parity_pkg::IDX_IRQ_STAT, 32'h00000000);
    wr(sc_parity_pkg::IDX_PAR_CTL, 8'h08);
    proto_t1 <= 1'b1;
    tx(8'hA5, 1'b0, 1'b1, 1'b0);
    proto_t1 <= 1'b0;
    rdc("t1 break ignored", sc_parity_pkg::IDX_IRQ_STAT, 32'h00000000);
  endtask

  // main sequence
  initial begin
    {psel, penable, pwrite, proto_t1, rx_start, rx_done, tx_start, card_brk} = '0;
    paddr = 32'h0;
    pwdata = 32'h0;
    tx_data = 8'h00;
    rx_char = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_clk;
    t_rx;
    t_tx;
    end_of_test;
  end

  // watchdog, well past the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
